// >>> rtl/wsg_pkg.sv
// Constants and types shared by the wait state generator.
package wsg_pkg;
  // I/O ports used to reach the control register file.
  localparam logic [7:0] WSG_PTR_PORT = 8'hEE;
  localparam logic [7:0] WSG_DATA_PORT = 8'hEF;
  localparam logic [7:0] WSG_WSC_INDEX = 8'h00;
  // Field positions of wait_state_control.
  localparam int WSG_DC_HI = 7;
  localparam int WSG_DC_LO = 6;
  localparam int WSG_VEC_BIT = 5;
  localparam int WSG_OPX_BIT = 4;
  localparam int WSG_MEM_HI = 3;
  localparam int WSG_MEM_LO = 2;
  localparam int WSG_IO_HI = 1;
  localparam int WSG_IO_LO = 0;
  localparam logic [7:0] WSG_WSC_RST = 8'hFF;
  localparam logic [7:0] WSG_WSC_AFTER = 8'h00;
  // Fetches with defaults in force; they drop on the next trailing edge.
  localparam logic [4:0] WSG_DEFAULT_FETCHES = 5'h0F;
  localparam logic [4:0] WSG_FETCH_SAT = 5'h10;
  // Opcodes of the return-from-interrupt pair.
  localparam logic [7:0] WSG_OP_PREFIX = 8'hED;
  localparam logic [7:0] WSG_OP_RETURN = 8'h4D;
  localparam logic [3:0] WSG_RETURN_WAIT_LO = 4'h2;
  localparam logic [3:0] WSG_RETURN_WAIT_HI = 4'h4;
  localparam logic [3:0] WSG_RETURN_WAIT_OTHER = 4'h1;
  // Cycle types given by the bus sequencer.
  localparam logic [2:0] WSG_CYC_MEM = 3'h0;
  localparam logic [2:0] WSG_CYC_FETCH = 3'h1;
  localparam logic [2:0] WSG_CYC_IO = 3'h2;
  localparam logic [2:0] WSG_CYC_SETTLE = 3'h3;
  localparam logic [2:0] WSG_CYC_VECTOR = 3'h4;
  // Clock is 100 ns; every wait state is one such period.
  localparam int WSG_CLK_NS = 100;
  localparam int WSG_WAIT_NS = 100;
  localparam int WSG_WAIT_CYC = (WSG_WAIT_NS + WSG_CLK_NS - 1) / WSG_CLK_NS;

  typedef enum logic [1:0] {
    WSG_IDLE = 2'b00,
    WSG_COUNT = 2'b01,
    WSG_EXTW = 2'b10
  } wsg_state_t;

  typedef struct packed {
    wsg_state_t st;
    logic [3:0] cnt;
    logic [2:0] cyc;
    logic [7:0] wsc;
    logic written;
    logic [4:0] fetch_cnt;
    logic fetch_d;
    logic prev_ed;
    logic [7:0] ptr;
    logic [2:0] ext_sync;
    logic ext_act;
    logic wait_q;
    logic [7:0] rdata;
    logic rvalid;
  } wsg_regs_t;
endpackage

// >>> rtl/wsg_top.sv
// Programmable wait state generator with its control register.
// What this block does
// RULE1: Acknowledge settle waits 0/2/4/6 by code.
// RULE2: Return fetch waits only for codes 10/11.
// RULE3: Return opcode gets 2 or 4 waits.
// RULE4: Other opcode after prefix gets one wait.
// RULE5: Vector bit adds one acknowledge wait.
// RULE6: Extension bit adds one fetch wait.
// RULE7: Memory field adds 0 to 3 waits.
// RULE8: I/O field adds 0/2/4/6 waits.
// RULE9: On-chip I/O adds no I/O field waits; external wait still applies.
// RULE10: Daisy field defaults 11 until 16th fetch.
// RULE11: Vector bit defaults one until 16th fetch.
// RULE12: Extension bit defaults one until 16th fetch.
// RULE13: Memory field defaults 11 until 16th fetch.
// RULE14: I/O field defaults 11 until 16th fetch.
// RULE15: Memory waits only inside boundary range.
// RULE16: External wait sampled after internal waits.
// RULE17: Register reached through pointer and data ports.
// RULE18: Each wait stretches one clock period.
`timescale 1ns/1ns
module wsg_top
  import wsg_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_CYC_START,
  input wire logic [2:0] I_CYC_TYPE,
  input wire logic [7:0] I_OPCODE,
  input wire logic I_MEM_IN_RANGE,
  input wire logic I_ONCHIP_IO,
  input wire logic I_OPFETCH_STROBE,
  input wire logic I_EXT_WAIT_N,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  output logic O_WAIT_REQ,
  output logic [7:0] O_RDATA,
  output logic O_RDATA_VALID,
  output logic [7:0] O_WAIT_CTRL
);
  wsg_regs_t s_r;
  wsg_regs_t s_nxt;
  logic [3:0] calc;
  logic [1:0] dc;
  logic [3:0] mem_w;
  logic wr_hit;
  logic fetch_edge;

  assign dc = s_r.wsc[WSG_DC_HI:WSG_DC_LO];
  // RULE17: pointer selects index
  assign wr_hit = I_IO_WR && (I_IO_ADDR == WSG_DATA_PORT) && (s_r.ptr == WSG_WSC_INDEX);
  assign fetch_edge = s_r.fetch_d && !I_OPFETCH_STROBE;
  // RULE15: range gates memory
  assign mem_w = I_MEM_IN_RANGE ? {2'b00, s_r.wsc[WSG_MEM_HI:WSG_MEM_LO]} : 4'h0;

  always_comb
  begin
    calc = 4'h0;
    unique case (I_CYC_TYPE)
      WSG_CYC_MEM:
      begin
        // RULE7: memory wait count
        calc = mem_w;
      end
      WSG_CYC_FETCH:
      begin
        // RULE6: extension adds one
        calc = mem_w + {3'b000, s_r.wsc[WSG_OPX_BIT]};
        // RULE2: return waits gated
        if (s_r.prev_ed && dc[1])
        begin
          // RULE3: return opcode waits
          if (I_OPCODE == WSG_OP_RETURN)
          begin
            calc = calc + (dc[0] ? WSG_RETURN_WAIT_HI : WSG_RETURN_WAIT_LO);
          end
          else
          begin
            // RULE4: single extra wait
            calc = calc + WSG_RETURN_WAIT_OTHER;
          end
        end
      end
      WSG_CYC_IO:
      begin
        // RULE8: doubled I/O code
        // RULE9: on-chip bypass
        calc = I_ONCHIP_IO ? 4'h0 : {1'b0, s_r.wsc[WSG_IO_HI:WSG_IO_LO], 1'b0};
      end
      WSG_CYC_SETTLE:
      begin
        // RULE1: doubled daisy code
        calc = {1'b0, dc, 1'b0};
      end
      WSG_CYC_VECTOR:
      begin
        // RULE5: vector wait bit
        calc = {3'b000, s_r.wsc[WSG_VEC_BIT]};
      end
      default:
      begin
        calc = 4'h0;
      end
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.fetch_d = I_OPFETCH_STROBE;
    s_nxt.ext_sync = {s_r.ext_sync[1:0], I_EXT_WAIT_N};
    if (s_r.ext_sync[1] == s_r.ext_sync[2])
    begin
      s_nxt.ext_act = !s_r.ext_sync[2];
    end
    if (fetch_edge && (s_r.fetch_cnt != WSG_FETCH_SAT))
    begin
      s_nxt.fetch_cnt = s_r.fetch_cnt + 5'h01;
      // RULE10: daisy default drop
      // RULE11: vector default drop
      // RULE12: extension default drop
      // RULE13: memory default drop
      // RULE14: I/O default drop
      if ((s_r.fetch_cnt == WSG_DEFAULT_FETCHES) && !s_r.written)
      begin
        s_nxt.wsc = WSG_WSC_AFTER;
      end
    end
    // RULE17: pointer and data ports
    if (I_IO_WR && (I_IO_ADDR == WSG_PTR_PORT))
    begin
      s_nxt.ptr = I_IO_WDATA;
    end
    if (wr_hit)
    begin
      s_nxt.wsc = I_IO_WDATA;
      s_nxt.written = 1'b1;
    end
    if (I_IO_RD)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = 8'h00;
      if (I_IO_ADDR == WSG_PTR_PORT)
      begin
        s_nxt.rdata = s_r.ptr;
      end
      else if ((I_IO_ADDR == WSG_DATA_PORT) && (s_r.ptr == WSG_WSC_INDEX))
      begin
        s_nxt.rdata = s_r.wsc;
      end
    end
    unique case (s_r.st)
      WSG_IDLE:
      begin
        if (I_CYC_START)
        begin
          s_nxt.cyc = I_CYC_TYPE;
          if (I_CYC_TYPE == WSG_CYC_FETCH)
          begin
            s_nxt.prev_ed = (I_OPCODE == WSG_OP_PREFIX);
          end
          // RULE18: one clock per wait
          if (calc != 4'h0)
          begin
            s_nxt.st = WSG_COUNT;
            s_nxt.cnt = calc - 4'(WSG_WAIT_CYC);
            s_nxt.wait_q = 1'b1;
          end
          else if (s_r.ext_act && (I_CYC_TYPE != WSG_CYC_SETTLE))
          begin
            s_nxt.st = WSG_EXTW;
            s_nxt.wait_q = 1'b1;
          end
        end
      end
      WSG_COUNT:
      begin
        if (s_r.cnt != 4'h0)
        begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
        // RULE16: external after internal
        else if (s_r.ext_act && (s_r.cyc != WSG_CYC_SETTLE))
        begin
          s_nxt.st = WSG_EXTW;
        end
        else
        begin
          s_nxt.st = WSG_IDLE;
          s_nxt.wait_q = 1'b0;
        end
      end
      WSG_EXTW:
      begin
        if (!s_r.ext_act)
        begin
          s_nxt.st = WSG_IDLE;
          s_nxt.wait_q = 1'b0;
        end
      end
      default:
      begin
        s_nxt.st = WSG_IDLE;
        s_nxt.wait_q = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_RST)
    begin
      s_r <= '0;
      s_r.wsc <= WSG_WSC_RST;
      s_r.ext_sync <= 3'b111;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign O_WAIT_REQ = s_r.wait_q;
  assign O_RDATA = s_r.rdata;
  assign O_RDATA_VALID = s_r.rvalid;
  assign O_WAIT_CTRL = s_r.wsc;

  logic go;
  assign go = I_CYC_START && (s_r.st == WSG_IDLE);

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  // RULE1: settle wait length
  chk_settle_six_waits: assert property ( // RULE1
    go && I_CYC_TYPE == WSG_CYC_SETTLE && dc == 2'b11
    |=> O_WAIT_REQ [*6] ##1 !O_WAIT_REQ) else $error("settle wait not six cycles");
  // RULE2: no return waits
  chk_return_low_code: assert property ( // RULE2
    go && I_CYC_TYPE == WSG_CYC_FETCH && s_r.prev_ed && !dc[1] && !I_MEM_IN_RANGE
    && !s_r.wsc[WSG_OPX_BIT] && !s_r.ext_act |=> !O_WAIT_REQ) else $error("return fetch waited");
  // RULE3: return opcode waits
  chk_return_four_waits: assert property ( // RULE3
    go && I_CYC_TYPE == WSG_CYC_FETCH && s_r.prev_ed && dc == 2'b11 && !I_MEM_IN_RANGE
    && !s_r.wsc[WSG_OPX_BIT] && I_OPCODE == WSG_OP_RETURN |=> O_WAIT_REQ [*4])
    else $error("return fetch not four waits");
  // RULE4: other opcode one wait
  chk_return_other_one: assert property ( // RULE4
    go && I_CYC_TYPE == WSG_CYC_FETCH && s_r.prev_ed && dc[1] && !I_MEM_IN_RANGE
    && !s_r.wsc[WSG_OPX_BIT] && I_OPCODE != WSG_OP_RETURN && !s_r.ext_act
    |=> O_WAIT_REQ ##1 !O_WAIT_REQ) else $error("prefixed fetch not one wait");
  // RULE5: vector wait bit
  chk_vector_wait: assert property ( // RULE5
    go && I_CYC_TYPE == WSG_CYC_VECTOR |=> O_WAIT_REQ == $past(s_r.wsc[WSG_VEC_BIT])
    || $past(s_r.ext_act)) else $error("vector wait mismatch");
  // RULE6: extension bit adds one
  chk_fetch_extension: assert property ( // RULE6
    go && I_CYC_TYPE == WSG_CYC_FETCH && s_r.wsc[WSG_OPX_BIT] |=> O_WAIT_REQ)
    else $error("fetch extension missing");
  // RULE7: memory field three
  chk_mem_three_waits: assert property ( // RULE7
    go && I_CYC_TYPE == WSG_CYC_MEM && I_MEM_IN_RANGE && s_r.wsc[WSG_MEM_HI:WSG_MEM_LO] == 2'b11
    |=> O_WAIT_REQ [*3]) else $error("memory wait not three");
  // RULE8: I/O field six
  chk_io_six_waits: assert property ( // RULE8
    go && I_CYC_TYPE == WSG_CYC_IO && !I_ONCHIP_IO && s_r.wsc[WSG_IO_HI:WSG_IO_LO] == 2'b11
    |=> O_WAIT_REQ [*6]) else $error("io wait not six");
  // RULE9: on-chip no waits
  chk_onchip_io_none: assert property ( // RULE9
    go && I_CYC_TYPE == WSG_CYC_IO && I_ONCHIP_IO && !s_r.ext_act |=> !O_WAIT_REQ)
    else $error("on-chip io waited");
  // RULE10: default drop at 16th fetch
  chk_default_drop: assert property ( // RULE10
    fetch_edge && s_r.fetch_cnt == WSG_DEFAULT_FETCHES && !s_r.written && !wr_hit
    |=> O_WAIT_CTRL == WSG_WSC_AFTER) else $error("defaults not dropped");
  // RULE11: defaults held early
  chk_default_hold: assert property ( // RULE11
    !s_r.written && s_r.fetch_cnt < WSG_DEFAULT_FETCHES |-> O_WAIT_CTRL == WSG_WSC_RST)
    else $error("defaults lost early");
  // RULE15: out of range no waits
  chk_mem_out_range: assert property ( // RULE15
    go && I_CYC_TYPE == WSG_CYC_MEM && !I_MEM_IN_RANGE && !s_r.ext_act |=> !O_WAIT_REQ)
    else $error("out of range memory waited");
  // RULE16: settle ignores external wait
  chk_settle_no_ext: assert property ( // RULE16
    s_r.st == WSG_COUNT && s_r.cnt == 4'h0 && s_r.cyc == WSG_CYC_SETTLE |=> !O_WAIT_REQ)
    else $error("settle extended by external wait");

  cov_settle_wait: cover property (go && I_CYC_TYPE == WSG_CYC_SETTLE && calc != 4'h0);
  cov_return_fetch: cover property (go && s_r.prev_ed && I_OPCODE == WSG_OP_RETURN && dc[1]);
  cov_ext_extend: cover property (s_r.st == WSG_EXTW);
  cov_default_drop: cover property (fetch_edge && s_r.fetch_cnt == WSG_DEFAULT_FETCHES);
endmodule // wsg_top

// >>> verif/wsg_slow_dev.sv
// Slow peripheral model that pulls the external wait line.
`timescale 1ns/1ns
module wsg_slow_dev
#(
  parameter int HOLD = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic i_wait_req,
  output logic o_ext_wait_n
);
  logic [3:0] cnt_r;
  logic req_d_r;
  always_ff @(posedge i_clk)
  begin
    req_d_r <= i_wait_req;
    if (i_rst)
      cnt_r <= 4'h0;
    else if (i_slow && i_wait_req && !req_d_r)
      cnt_r <= 4'(HOLD);
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  // A released pin returns to its pull-up level.
  assign o_ext_wait_n = (cnt_r == 4'h0);
endmodule // wsg_slow_dev

// >>> verif/tb_programmable_wait_state_generator.sv
// Self-checking bench for the wait state generator.
`timescale 1ns/1ns
module tb_programmable_wait_state_generator;
  import wsg_pkg::*;
  logic clk, rst, start, strobe, io_wr, io_rd, rng, onc, slow, ext_n, wreq, rvalid, wrt, pe;
  logic [2:0] ctype;
  logic [7:0] op, addr, wdata, rdata, wctrl, w;
  logic [31:0] seed, r;
  int fails, n_compared, nf, cycles;
  wsg_top dut_u (.I_CORE_CLK(clk), .I_RST(rst), .I_CYC_START(start), .I_CYC_TYPE(ctype),
    .I_OPCODE(op), .I_MEM_IN_RANGE(rng), .I_ONCHIP_IO(onc), .I_OPFETCH_STROBE(strobe),
    .I_EXT_WAIT_N(ext_n), .I_IO_WR(io_wr), .I_IO_RD(io_rd), .I_IO_ADDR(addr),
    .I_IO_WDATA(wdata), .O_WAIT_REQ(wreq), .O_RDATA(rdata), .O_RDATA_VALID(rvalid),
    .O_WAIT_CTRL(wctrl));
  wsg_slow_dev slow_u (.i_clk(clk), .i_rst(rst), .i_slow(slow), .i_wait_req(wreq),
    .o_ext_wait_n(ext_n));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int exp_n(logic [2:0] t, logic [7:0] c, logic [7:0] o, logic p,
    logic ir, logic oc);
    int m;
    m = ir ? int'(c[3:2]) : 0;
    case (t)
      WSG_CYC_MEM: return m;
      WSG_CYC_FETCH:
      begin
        m = m + int'(c[4]);
        if (p && c[7])
          m = m + ((o == WSG_OP_RETURN) ? (c[6] ? 4 : 2) : 1);
        return m;
      end
      WSG_CYC_IO: return oc ? 0 : 2 * int'(c[1:0]);
      WSG_CYC_SETTLE: return 2 * int'(c[7:6]);
      default: return int'(c[5]);
    endcase
  endfunction
  task automatic results();
    if (fails == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    io_wr <= 1'b0;
  endtask
  task automatic setw(input logic [7:0] d);
    wr(WSG_PTR_PORT, WSG_WSC_INDEX);
    wr(WSG_DATA_PORT, d);
    w = d;
    wrt = 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    io_rd <= 1'b0;
    #1;
    chk(rvalid === 1'b1 && rdata === d, "register read");
    @(posedge clk);
    #1;
    chk(rvalid === 1'b0 && rdata === d, "read valid held too long");
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    w = WSG_WSC_RST;
    nf = 0;
    wrt = 1'b0;
    pe = 1'b0;
    #1;
    chk(wctrl === WSG_WSC_RST && wreq === 1'b0 && rdata === 8'h00, "reset values");
  endtask
  // Runs one bus cycle and counts the cycles for which the wait request stands.
  task automatic cyc(input logic [2:0] t, input logic [7:0] o, input logic ir, input logic oc);
    int e;
    int n;
    e = exp_n(t, w, o, pe, ir, oc);
    n = 0;
    @(posedge clk);
    start <= 1'b1;
    ctype <= t;
    op <= o;
    rng <= ir;
    onc <= oc;
    strobe <= (t == WSG_CYC_FETCH);
    if (t == WSG_CYC_FETCH)
      pe = (o == WSG_OP_PREFIX);
    @(posedge clk);
    start <= 1'b0;
    // The wait request is already up after the edge that takes the start.
    repeat (20)
    begin
      #1;
      n += int'(wreq === 1'b1);
      @(posedge clk);
    end
    if (slow && t != WSG_CYC_SETTLE)
      chk(n > e && n < e + 10, "slow device stretch");
    else
      chk(n == e, "wait count");
    strobe <= 1'b0;
    if (t == WSG_CYC_FETCH)
      nf++;
    if (nf == 16 && !wrt)
      w = WSG_WSC_AFTER;
    repeat (2) @(posedge clk);
    #1;
    chk(wctrl === w, "control register value");
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    {rst, start, strobe, io_wr, io_rd, rng, onc, slow} = 8'h00;
    {ctype, op, addr, wdata} = 27'h0;
    seed = 32'h0000_0056;
    do_reset();
    for (int i = 0; i < 16; i++)
      cyc(WSG_CYC_FETCH, (i % 2 == 0) ? WSG_OP_PREFIX : ((i % 4 == 1) ? WSG_OP_RETURN
        : 8'(rnd())), 1'b1, 1'b0);
    wr(WSG_PTR_PORT, 8'h01);
    wr(WSG_DATA_PORT, 8'hA5);
    rd(WSG_DATA_PORT, 8'h00);
    rd(WSG_PTR_PORT, 8'h01);
    rd(8'h10, 8'h00);
    setw(8'h3C);
    rd(WSG_DATA_PORT, 8'h3C);
    for (int i = 0; i < 300; i++)
    begin
      r = rnd();
      if (r[1:0] == 2'b00)
        setw(r[15:8]);
      cyc(3'(r[18:16] % 3'd5), r[20] ? (r[21] ? WSG_OP_PREFIX : WSG_OP_RETURN) : r[31:24],
        r[22], r[23]);
    end
    setw(8'h03);
    slow <= 1'b1;
    cyc(WSG_CYC_IO, 8'h00, 1'b0, 1'b0);
    setw(8'hC0);
    cyc(WSG_CYC_SETTLE, 8'h00, 1'b0, 1'b0);
    @(posedge clk);
    slow <= 1'b0;
    do_reset();
    setw(8'h5A);
    for (int i = 0; i < 16; i++)
      cyc(WSG_CYC_FETCH, 8'(rnd()), 1'b1, 1'b0);
    results();
  end
endmodule // tb_programmable_wait_state_generator
